// [rtl/cas_defines.svh]
/*
  constants for the comparator alert status bank: register offsets,
  field widths, reset values and scan codes.
  assumes it is included by bare name from rtl/ sources.
*/
// What this block does
// - cell undervoltage flag per enabled cell
// - cell undervoltage flag clears when resolved
// - aux cold flag per enabled input
// - aux cold flag clears when resolved
// - aux hot flag per enabled input
// - aux hot flag clears when resolved
// - balance switch fault flags from diagnostic scans
// - balance fault clears when resolved
// - alert registers read only, writes ignored
// - writing one starts software reset
// - software reset bit always reads zero
`ifndef CAS_DEFINES_SVH
`define CAS_DEFINES_SVH

`define CAS_ADDR_W        8
`define CAS_DATA_W        16
`define CAS_CELLS         14
`define CAS_AUX           6
`define CAS_OFS_CELL_UV   8'h0f
`define CAS_OFS_AUX_COLD  8'h10
`define CAS_OFS_AUX_HOT   8'h11
`define CAS_OFS_BAL_SW    8'h12
`define CAS_OFS_SW_RESET  8'h13
`define CAS_OFS_IRQ_STAT  8'h20
`define CAS_OFS_IRQ_MASK  8'h21
`define CAS_OFS_ENABLES   8'h22
`define CAS_OFS_AUX_EN    8'h23
`define CAS_OFS_TOP_CELL  8'h24
`define CAS_SW_RESET_BIT  0
`define CAS_SCAN_BAL_LO   3'h4
`define CAS_IRQ_W         4
`define CAS_IRQ_CELL_UV   0
`define CAS_IRQ_AUX_COLD  1
`define CAS_IRQ_AUX_HOT   2
`define CAS_IRQ_BAL_SW    3
`define CAS_RST_CELL      14'h0000
`define CAS_RST_AUX       6'h00
`define CAS_RST_IRQ       4'h0
`define CAS_RST_CELL_EN   14'h3fff
`define CAS_RST_AUX_EN    6'h3f
`define CAS_RST_TOP_CELL  4'hd
`define CAS_TOP_W         4

`endif

// [rtl/cas_pkg.sv]
/*
  types for the comparator alert status bank.
  assumes cas_defines.svh is on the include path.
*/
`default_nettype none
`include "cas_defines.svh"
package cas_pkg;
  typedef logic [`CAS_CELLS-1:0]  cas_cell_t;
  typedef logic [`CAS_AUX-1:0]    cas_aux_t;
  typedef logic [`CAS_DATA_W-1:0] cas_word_t;
endpackage
`default_nettype wire

// [rtl/cas_alert_regs.sv]
/*
  comparator and balance-switch alert status registers, software reset
  request, interrupt status and mask.
  assumes a synchronous register port, acquisition results presented with
  a one-cycle done strobe, and that the chip reset tree takes sw_reset_out.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cas_defines.svh"
module cas_alert_regs (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic [`CAS_ADDR_W-1:0]    reg_addr,
  input  wire logic [`CAS_DATA_W-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`CAS_DATA_W-1:0]    reg_rdata,
  input  wire logic                      comp_done,
  input  wire cas_pkg::cas_cell_t        comp_cell_below,
  input  wire cas_pkg::cas_aux_t         comp_aux_above,
  input  wire cas_pkg::cas_aux_t         comp_aux_below,
  input  wire logic                      adc_done,
  input  wire logic [2:0]                scan_configuration,
  input  wire cas_pkg::cas_cell_t        bal_sw_fail,
  output logic                           irq,
  output logic                           sw_reset_out
);

  cas_pkg::cas_cell_t cell_uv_comp_flags;
  cas_pkg::cas_aux_t  aux_cold_comp_flags;
  cas_pkg::cas_aux_t  aux_hot_comp_flags;
  cas_pkg::cas_cell_t balance_switch_fault_flags;
  cas_pkg::cas_cell_t cell_undervoltage_alert_enable;
  cas_pkg::cas_aux_t  aux_cold_alert_enable;
  cas_pkg::cas_aux_t  aux_hot_alert_enable;
  logic [`CAS_TOP_W-1:0] top_cell_positions;
  logic [`CAS_IRQ_W-1:0] irq_status;
  logic [`CAS_IRQ_W-1:0] irq_mask;
  logic                  software_reset_pulse;

  // decode of a register offset, used by both read and write paths
  function automatic logic hit(input logic [`CAS_ADDR_W-1:0] a,
                               input logic [`CAS_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // cells above the configured top cell are masked out of the balance switch fault flags
  cas_pkg::cas_cell_t top_mask;
  genvar gi;
  generate
    for (gi = 0; gi < `CAS_CELLS; gi = gi + 1)
    begin : g_top
      assign top_mask[gi] = (gi <= top_cell_positions);
    end
  endgenerate

  // next flag values: each comparator acquisition, and each diagnostic scan for the switch flags, re-evaluates, so resolved faults clear
  wire bal_scan = scan_configuration >= `CAS_SCAN_BAL_LO;
  wire bal_done = adc_done & bal_scan;
  cas_pkg::cas_cell_t next_cell_uv;
  cas_pkg::cas_aux_t  next_aux_cold;
  cas_pkg::cas_aux_t  next_aux_hot;
  cas_pkg::cas_cell_t next_bal_sw;
  assign next_cell_uv  = comp_done ? (comp_cell_below & cell_undervoltage_alert_enable)
                                   : cell_uv_comp_flags;
  assign next_aux_cold = comp_done ? (comp_aux_above & aux_cold_alert_enable)
                                   : aux_cold_comp_flags;
  assign next_aux_hot  = comp_done ? (comp_aux_below & aux_hot_alert_enable)
                                   : aux_hot_comp_flags;
  assign next_bal_sw   = bal_done ? (bal_sw_fail & top_mask)
                                  : (balance_switch_fault_flags & top_mask);

  // write decodes; alert registers have no write path at all
  wire wr_sw    = reg_wr & hit(reg_addr, `CAS_OFS_SW_RESET);
  wire wr_stat  = reg_wr & hit(reg_addr, `CAS_OFS_IRQ_STAT);
  wire wr_mask  = reg_wr & hit(reg_addr, `CAS_OFS_IRQ_MASK);
  wire wr_en    = reg_wr & hit(reg_addr, `CAS_OFS_ENABLES);
  wire wr_auxen = reg_wr & hit(reg_addr, `CAS_OFS_AUX_EN);
  wire wr_top   = reg_wr & hit(reg_addr, `CAS_OFS_TOP_CELL);
  wire sw_req   = wr_sw & reg_wdata[`CAS_SW_RESET_BIT];
  wire any_rst  = srst | software_reset_pulse;

  // events: a flag register gaining a new set bit
  logic [`CAS_IRQ_W-1:0] ev;
  assign ev[`CAS_IRQ_CELL_UV]  = |(next_cell_uv & ~cell_uv_comp_flags);
  assign ev[`CAS_IRQ_AUX_COLD] = |(next_aux_cold & ~aux_cold_comp_flags);
  assign ev[`CAS_IRQ_AUX_HOT]  = |(next_aux_hot & ~aux_hot_comp_flags);
  assign ev[`CAS_IRQ_BAL_SW]   = |(next_bal_sw & ~balance_switch_fault_flags);
  wire [`CAS_IRQ_W-1:0] next_irq_status =
    (irq_status & ~(wr_stat ? reg_wdata[`CAS_IRQ_W-1:0] : `CAS_RST_IRQ)) | ev;

  // read mux, unused bits and unmapped offsets read zero
  cas_pkg::cas_word_t rd_mux;
  assign rd_mux =
    hit(reg_addr, `CAS_OFS_CELL_UV)  ? {2'h0, cell_uv_comp_flags} :
    hit(reg_addr, `CAS_OFS_AUX_COLD) ? {10'h000, aux_cold_comp_flags} :
    hit(reg_addr, `CAS_OFS_AUX_HOT)  ? {10'h000, aux_hot_comp_flags} :
    hit(reg_addr, `CAS_OFS_BAL_SW)   ? {2'h0, balance_switch_fault_flags} :
    hit(reg_addr, `CAS_OFS_IRQ_STAT) ? {12'h000, irq_status} :
    hit(reg_addr, `CAS_OFS_IRQ_MASK) ? {12'h000, irq_mask} :
    hit(reg_addr, `CAS_OFS_ENABLES)  ? {2'h0, cell_undervoltage_alert_enable} :
    hit(reg_addr, `CAS_OFS_AUX_EN)   ? {4'h0, aux_hot_alert_enable, aux_cold_alert_enable} :
    hit(reg_addr, `CAS_OFS_TOP_CELL) ? {12'h000, top_cell_positions} :
    16'h0000;

  // software reset pulse, one cycle, ends itself
  always_ff @(posedge clk)
  begin
    if (srst)
      software_reset_pulse <= 1'b0;
    else
      software_reset_pulse <= sw_req & ~software_reset_pulse;
  end

  // alert flags and interrupt status
  always_ff @(posedge clk)
  begin
    if (any_rst)
    begin
      cell_uv_comp_flags         <= `CAS_RST_CELL;
      aux_cold_comp_flags        <= `CAS_RST_AUX;
      aux_hot_comp_flags         <= `CAS_RST_AUX;
      balance_switch_fault_flags <= `CAS_RST_CELL;
      irq_status                 <= `CAS_RST_IRQ;
    end
    else
    begin
      cell_uv_comp_flags         <= next_cell_uv;
      aux_cold_comp_flags        <= next_aux_cold;
      aux_hot_comp_flags         <= next_aux_hot;
      balance_switch_fault_flags <= next_bal_sw;
      irq_status                 <= next_irq_status;
    end
  end

  // software-written configuration
  always_ff @(posedge clk)
  begin
    if (any_rst)
    begin
      irq_mask                       <= `CAS_RST_IRQ;
      cell_undervoltage_alert_enable <= `CAS_RST_CELL_EN;
      aux_cold_alert_enable          <= `CAS_RST_AUX_EN;
      aux_hot_alert_enable           <= `CAS_RST_AUX_EN;
      top_cell_positions             <= `CAS_RST_TOP_CELL;
    end
    else
    begin
      if (wr_mask)
        irq_mask <= reg_wdata[`CAS_IRQ_W-1:0];
      if (wr_en)
        cell_undervoltage_alert_enable <= reg_wdata[`CAS_CELLS-1:0];
      if (wr_auxen)
        {aux_hot_alert_enable, aux_cold_alert_enable} <= reg_wdata[2*`CAS_AUX-1:0];
      if (wr_top)
        top_cell_positions <= reg_wdata[`CAS_TOP_W-1:0];
    end
  end

  // registered outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata    <= 16'h0000;
      irq          <= 1'b0;
      sw_reset_out <= 1'b0;
    end
    else
    begin
      reg_rdata    <= reg_rd ? rd_mux : 16'h0000;
      irq          <= |(next_irq_status & irq_mask) & ~software_reset_pulse;
      sw_reset_out <= sw_req & ~software_reset_pulse;
    end
  end

endmodule
`default_nettype wire

// [dv/cas_alert_properties.sv]
/* port checker for the alert bank.
   bound from tb_top; one clock, srst resets. */
`timescale 1ns/1ps
`default_nettype none
module cas_alert_props (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic [7:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  input wire logic               comp_done,
  input wire cas_pkg::cas_cell_t comp_cell_below,
  input wire cas_pkg::cas_aux_t  comp_aux_above,
  input wire cas_pkg::cas_aux_t  comp_aux_below,
  input wire logic               sw_reset_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // reset request pulse and readback
  a_software_reset_pulse_pulse: assert property (reg_wr && reg_addr == 8'h13 && reg_wdata[0] |=> sw_reset_out)
    else $error("no reset pulse");
  a_software_reset_pulse_cause: assert property (sw_reset_out |-> $past(reg_wr && reg_addr == 8'h13))
    else $error("stray reset pulse");
  a_software_reset_pulse_zero: assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata == 16'h0000)
    else $error("reset bit read nonzero");
  // unused upper bits
  a_upper_zero: assert property ($past(reg_rd) |-> reg_rdata[15:14] == 2'h0)
    else $error("upper bits set");
  a_aux_upper: assert property ($past(reg_rd && reg_addr inside {8'h10, 8'h11}) |-> reg_rdata[15:6] == 10'h000)
    else $error("aux upper bits set");
  // a flag read right after an acquisition needs its condition
  a_cell_cause: assert property ($past(comp_done, 2) && reg_rd && reg_addr == 8'h0f
    |=> (reg_rdata[13:0] & ~$past(comp_cell_below, 3)) == 14'h0000)
    else $error("cell flag without cause");
  a_cold_cause: assert property ($past(comp_done, 2) && reg_rd && reg_addr == 8'h10
    |=> (reg_rdata[5:0] & ~$past(comp_aux_above, 3)) == 6'h00)
    else $error("cold flag without cause");
  a_hot_cause: assert property ($past(comp_done, 2) && reg_rd && reg_addr == 8'h11
    |=> (reg_rdata[5:0] & ~$past(comp_aux_below, 3)) == 6'h00)
    else $error("hot flag without cause");
endmodule
`default_nettype wire

// [dv/cas_host_model.sv]
/* host side of the register port.
   assumes clk from tb_top; read data taken in the cycle after the strobe. */
`timescale 1ns/1ps
`default_nettype none
module cas_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [7:0]  reg_addr = 8'h00,
  output logic      [15:0] reg_wdata = 16'h0000,
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0
);
  // one write cycle; data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask
  // one read cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
/* bench for the alert bank: host model drives the register port,
   this module drives acquisitions and judges every result. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic [7:0]         a;
  logic [15:0]        wd;
  logic               wr;
  logic               rd;
  logic [15:0]        rdat;
  logic               cd = 1'b0;
  cas_pkg::cas_cell_t cb = '0;
  cas_pkg::cas_aux_t  ca = '0;
  cas_pkg::cas_aux_t  cl = '0;
  logic               ad = 1'b0;
  logic [2:0]         sc = 3'h0;
  cas_pkg::cas_cell_t bf = '0;
  logic               irq;
  int                 n_mismatch = 0;
  int                 n_checks = 0;
  logic [15:0]        v;
  // clock and instances
  always #5 clk = ~clk;
  cas_host_model i_host (.clk(clk), .reg_rdata(rdat), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd));
  cas_alert_regs i_dut (.clk(clk), .srst(srst), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .comp_done(cd), .comp_cell_below(cb), .comp_aux_above(ca),
    .comp_aux_below(cl), .adc_done(ad), .scan_configuration(sc), .bal_sw_fail(bf),
    .irq(irq), .sw_reset_out());
  // compare, read-compare, irq compare
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("Error %0t got %h exp %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic rc(input logic [7:0] ra, input logic [15:0] e);
    i_host.rd(ra, v);
    chk(v, e);
  endtask
  task automatic ic(input logic e);
    #1 chk({15'h0000, irq}, {15'h0000, e});
    @(posedge clk);
  endtask
  // one acquisition; inputs scrambled afterwards
  task automatic acq(input logic [13:0] c, input logic [5:0] h, input logic [5:0] l);
    cd <= 1'b1;
    cb <= c;
    ca <= h;
    cl <= l;
    @(posedge clk);
    cd <= 1'b0;
    cb <= ~c;
    ca <= ~h;
    cl <= ~l;
    @(posedge clk);
  endtask
  task automatic bal(input logic [2:0] s, input logic [13:0] f);
    ad <= 1'b1;
    sc <= s;
    bf <= f;
    @(posedge clk);
    ad <= 1'b0;
    bf <= ~f;
    @(posedge clk);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    i_host.wr(8'h22, 16'h3ffe);
    i_host.wr(8'h23, 16'h0ffe);
    acq(14'h2001, 6'h21, 6'h3f);
    rc(8'h0f, 16'h2000);
    rc(8'h10, 16'h0020);
    rc(8'h11, 16'h003f);
    i_host.wr(8'h0f, 16'hffff);
    rc(8'h0f, 16'h2000);
    acq(14'h0000, 6'h00, 6'h00);
    rc(8'h0f, 16'h0000);
    rc(8'h10, 16'h0000);
    rc(8'h11, 16'h0000);
    i_host.wr(8'h24, 16'h0007);
    bal(3'h3, 14'h3fff);
    rc(8'h12, 16'h0000);
    for (int s = 4; s < 8; s++)
    begin
      bal(s[2:0], 14'h0001 << s);
      rc(8'h12, 16'h0001 << s);
    end
    bal(3'h4, 14'h3fff);
    rc(8'h12, 16'h00ff);
    bal(3'h5, 14'h0000);
    rc(8'h12, 16'h0000);
    i_host.wr(8'h20, 16'h000f);
    i_host.wr(8'h21, 16'h0001);
    acq(14'h2000, 6'h00, 6'h00);
    rc(8'h20, 16'h0001);
    ic(1'b1);
    i_host.wr(8'h21, 16'h0000);
    ic(1'b0);
    i_host.wr(8'h21, 16'h0001);
    i_host.wr(8'h20, 16'h0001);
    ic(1'b0);
    i_host.wr(8'h13, 16'h0000);
    rc(8'h22, 16'h3ffe);
    i_host.wr(8'h13, 16'h0001);
    rc(8'h13, 16'h0000);
    rc(8'h22, 16'h3fff);
    rc(8'h0f, 16'h0000);
    rc(8'h30, 16'h0000);
    wrap_up();
  end
  // watchdog far beyond the roughly 90 cycles needed
  initial
  begin
    #50000;
    n_mismatch++;
    wrap_up();
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
endmodule
bind cas_alert_regs cas_alert_props i_props (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .comp_done(comp_done), .comp_cell_below(comp_cell_below), .comp_aux_above(comp_aux_above),
  .comp_aux_below(comp_aux_below), .sw_reset_out(sw_reset_out));
`default_nettype wire
